// ### mflc_lock_detect.sv
// Lock detectors comparing synchronised measurements with selected thresholds
`timescale 1ns/1ns
module mflc_lock_detect
  import mflc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Measurements from the analog front end
  input wire logic [7:0] speed_pct,
  input wire logic [7:0] backemf_pct,
  input wire logic [11:0] current_ma,
  // Setup
  input wire logic overspeed_lock_on,
  input wire logic low_backemf_lock_on,
  input wire logic absent_motor_lock_on,
  input wire logic [2:0] overspeed_lock_level,
  input wire logic [2:0] backemf_lock_level,
  input wire logic [2:0] absent_motor_current_level,
  // Faults
  output logic ovs_fault,
  output logic bemf_fault,
  output logic nomtr_fault
);
  import mflc_pkg::*;

  logic [27:0] meta_r;
  logic [27:0] sync_r;
  logic [7:0] spd_s;
  logic [7:0] bemf_s;
  logic [11:0] cur_s;

  // Slow-moving measurement words; a torn sample only shifts one compare by a cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_r <= 28'h0000000;
      sync_r <= 28'h0000000;
    end else begin
      meta_r <= {speed_pct, backemf_pct, current_ma};
      sync_r <= meta_r;
    end
  end

  assign {spd_s, bemf_s, cur_s} = sync_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ovs_fault <= 1'b0;
      bemf_fault <= 1'b0;
      nomtr_fault <= 1'b0;
    end else begin
      ovs_fault <= overspeed_lock_on && (spd_s >= mflc_ovs_pct(overspeed_lock_level));
      bemf_fault <= low_backemf_lock_on && (bemf_s < mflc_bemf_pct(backemf_lock_level));
      nomtr_fault <= absent_motor_lock_on && (cur_s < mflc_nomtr_ma(absent_motor_current_level));
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_ovs_off;
    @(posedge ref_clk) disable iff (!rst_n) !overspeed_lock_on |=> !ovs_fault;
  endproperty
  a_ovs_off: assert property (p_ovs_off) else $error("overspeed fault while off");

  property p_bemf_off;
    @(posedge ref_clk) disable iff (!rst_n) !low_backemf_lock_on |=> !bemf_fault;
  endproperty
  a_bemf_off: assert property (p_bemf_off) else $error("back-EMF fault while off");

  property p_nomtr_off;
    @(posedge ref_clk) disable iff (!rst_n) !absent_motor_lock_on |=> !nomtr_fault;
  endproperty
  a_nomtr_off: assert property (p_nomtr_off) else $error("absent motor fault while off");

  property p_ovs_level;
    @(posedge ref_clk) disable iff (!rst_n)
      overspeed_lock_on && overspeed_lock_level == 3'h7 && spd_s == 8'hc7 |=> !ovs_fault;
  endproperty
  a_ovs_level: assert property (p_ovs_level) else $error("overspeed below 200 pct");

  property p_bemf_level;
    @(posedge ref_clk) disable iff (!rst_n)
      low_backemf_lock_on && backemf_lock_level == 3'h0 && bemf_s == 8'h09 |=> bemf_fault;
  endproperty
  a_bemf_level: assert property (p_bemf_level) else $error("back-EMF below 10 pct missed");

  property p_nomtr_level;
    @(posedge ref_clk) disable iff (!rst_n)
      absent_motor_lock_on && absent_motor_current_level == 3'h4 && cur_s == 12'h0fa
      |=> !nomtr_fault;
  endproperty
  a_nomtr_level: assert property (p_nomtr_level) else $error("0.25 A level wrong");

  property p_ovs_cause;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(ovs_fault) |-> $past(spd_s) >= mflc_ovs_pct($past(overspeed_lock_level));
  endproperty
  a_ovs_cause: assert property (p_ovs_cause) else $error("overspeed fault uncaused");

endmodule : mflc_lock_detect

// ### mflc_pkg.sv
// Shared constants, types and helpers for the motor fault and lock setup block
package mflc_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] MFLC_IDX_SETUP_A = 8'h91;
  localparam logic [7:0] MFLC_IDX_SETUP_B = 8'h92;
  localparam logic [7:0] MFLC_IDX_STATUS = 8'h93;
  localparam logic [7:0] MFLC_IDX_MASK = 8'h94;
  localparam logic [7:0] MFLC_IDX_STATE = 8'h95;

  // ---------------------------------------------------------------
  // Reset values and implemented bits
  // ---------------------------------------------------------------
  localparam logic [31:0] MFLC_SETUP_A_RST = 32'h00000000;
  localparam logic [31:0] MFLC_SETUP_A_BITS = 32'h00000007;
  localparam logic [31:0] MFLC_SETUP_B_RST = 32'h00000000;
  localparam logic [5:0] MFLC_EVT_RST = 6'h00;
  localparam int MFLC_EVT_W = 6;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MFLC_A_IPD_TIMEOUT = 2;
  localparam int MFLC_A_IPD_FREQ = 1;
  localparam int MFLC_A_SAT = 0;
  localparam int MFLC_B_PARITY = 31;
  localparam int MFLC_B_OVS_ON = 30;
  localparam int MFLC_B_BEMF_ON = 29;
  localparam int MFLC_B_NOMTR_ON = 28;
  localparam int MFLC_B_OVS_LVL = 25;
  localparam int MFLC_B_BEMF_LVL = 22;
  localparam int MFLC_B_NOMTR_LVL = 19;
  localparam int MFLC_B_ILIM_ACT = 15;

  // Status and mask bit positions
  localparam int MFLC_S_OVS = 0;
  localparam int MFLC_S_BEMF = 1;
  localparam int MFLC_S_NOMTR = 2;
  localparam int MFLC_S_IPD_TO = 3;
  localparam int MFLC_S_IPD_FREQ = 4;
  localparam int MFLC_S_ILIM = 5;

  // ---------------------------------------------------------------
  // Threshold encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] MFLC_OVS_BASE_PCT = 8'h82;
  localparam logic [7:0] MFLC_BEMF_BASE_PCT = 8'h0a;
  localparam logic [7:0] MFLC_STEP_PCT = 8'h0a;
  localparam logic [3:0] MFLC_ILIM_REPORT = 4'h8;

  typedef enum logic [0:0] {MFLC_BUS_IDLE, MFLC_BUS_ACK} mflc_bus_state_type;

  typedef struct packed {
    logic latch;
    logic retry;
    logic report;
    logic [1:0] action;
  } mflc_ilim_type;

  // Overspeed threshold in percent of maximum speed
  function automatic logic [7:0] mflc_ovs_pct(input logic [2:0] code);
    mflc_ovs_pct = 8'(MFLC_OVS_BASE_PCT + MFLC_STEP_PCT * {5'h00, code});
  endfunction : mflc_ovs_pct

  // Low back-EMF threshold in percent of expected back-EMF
  function automatic logic [7:0] mflc_bemf_pct(input logic [2:0] code);
    mflc_bemf_pct = 8'(MFLC_BEMF_BASE_PCT + MFLC_STEP_PCT * {5'h00, code});
  endfunction : mflc_bemf_pct

  // Absent-motor current threshold in milliamperes
  function automatic logic [11:0] mflc_nomtr_ma(input logic [2:0] code);
    case (code)
      3'h0: mflc_nomtr_ma = 12'h032;
      3'h1: mflc_nomtr_ma = 12'h04b;
      3'h2: mflc_nomtr_ma = 12'h064;
      3'h3: mflc_nomtr_ma = 12'h07d;
      3'h4: mflc_nomtr_ma = 12'h0fa;
      3'h5: mflc_nomtr_ma = 12'h1f4;
      3'h6: mflc_nomtr_ma = 12'h2ee;
      default: mflc_nomtr_ma = 12'h3e8;
    endcase
  endfunction : mflc_nomtr_ma

  // Current-limit lock response for a given code and event
  function automatic mflc_ilim_type mflc_ilim_decode(input logic [3:0] code,
                                                     input logic evt);
    mflc_ilim_decode.latch = evt && (code[3:2] == 2'h0);
    mflc_ilim_decode.retry = evt && (code[3:2] == 2'h1);
    mflc_ilim_decode.report = evt && (code == MFLC_ILIM_REPORT);
    mflc_ilim_decode.action = code[3] ? 2'h0 : code[1:0];
  endfunction : mflc_ilim_decode

endpackage : mflc_pkg

// ### mflc_reg_if.sv
// Register access carrier between the bus slave and the register bank
`timescale 1ns/1ns
interface mflc_reg_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic [31:0] wdata;
  logic [3:0] sel;
  logic [31:0] rd_data;
  logic [31:0] rdata;

  modport slave (output wr_en, output rd_en, output idx, output wdata, output sel,
                 output rd_data, input rdata);
  modport regs (input wr_en, input rd_en, input idx, input wdata, input sel,
                input rd_data, output rdata);
endinterface : mflc_reg_if

// ### mflc_top.sv
// Fault and motor-lock setup register bank with lock supervision and interrupt
//
// Summary of operation
// - Setup A bit 2 enables init-position timeout fault
// - Setup A bit 1 enables init-position frequency fault
// - Setup A bit 0 gates loop saturation reports
// - Setup B sits at index 92h, resets zero
// - Setup B bit 30 enables overspeed lock
// - Setup B bit 29 enables low back-EMF lock
// - Setup B bit 28 enables absent-motor lock
// - Bits 27-25: overspeed level 130 to 200 percent
// - Bits 24-22: back-EMF level 10 to 80 percent
// - Bits 21-19: absent-motor current 0.05 to 1.0 A
// - Bits 18-15: current-limit lock response code
`timescale 1ns/1ns
module mflc_top
  import mflc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Measurements (asynchronous, from the analog front end)
  input wire logic [7:0] speed_pct,
  input wire logic [7:0] backemf_pct,
  input wire logic [11:0] current_ma,
  // Events from control logic on this clock
  input wire logic ipd_timeout_evt,
  input wire logic ipd_freq_evt,
  input wire logic cur_loop_sat,
  input wire logic spd_loop_sat,
  input wire logic hw_ilimit_evt,
  // Fault outputs
  output logic overspeed_lock_fault,
  output logic low_backemf_lock_fault,
  output logic absent_motor_lock_fault,
  output logic init_position_timeout_fault,
  output logic init_position_freq_fault,
  output logic [1:0] loop_sat_report,
  // Current-limit lock response
  output logic ilim_fault_latch,
  output logic ilim_fault_retry,
  output logic ilim_report_only,
  output logic [1:0] ilim_gate_action,
  // Interrupt
  output logic irq
);
  import mflc_pkg::*;

  mflc_reg_if rif ();

  logic [31:0] setup_a_r;
  logic [31:0] setup_b_r;
  logic [5:0] status_r;
  logic [5:0] mask_r;
  logic [5:0] evt;
  logic [5:0] rd_clr;
  logic ovs_f;
  logic bemf_f;
  logic nomtr_f;
  mflc_ilim_type ilim;
  logic [3:0] ilim_code;

  // ---------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------
  mflc_wb_slave u_bus (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rif(rif)
  );

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  // ---------------------------------------------------------------
  // Setup registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      setup_a_r <= MFLC_SETUP_A_RST;
    end else if (rif.wr_en && rif.idx == MFLC_IDX_SETUP_A) begin
      setup_a_r <= merge(setup_a_r, rif.wdata, rif.sel) & MFLC_SETUP_A_BITS;
    end
  end

  // Parity bit is stored only; nothing here checks it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      setup_b_r <= MFLC_SETUP_B_RST;
    end else if (rif.wr_en && rif.idx == MFLC_IDX_SETUP_B) begin
      setup_b_r <= merge(setup_b_r, rif.wdata, rif.sel);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mask_r <= MFLC_EVT_RST;
    end else if (rif.wr_en && rif.idx == MFLC_IDX_MASK && rif.sel[0]) begin
      mask_r <= rif.wdata[5:0];
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    case (rif.idx)
      MFLC_IDX_SETUP_A: rif.rdata = setup_a_r;
      MFLC_IDX_SETUP_B: rif.rdata = setup_b_r;
      MFLC_IDX_STATUS: rif.rdata = {26'h0000000, status_r};
      MFLC_IDX_MASK: rif.rdata = {26'h0000000, mask_r};
      MFLC_IDX_STATE: rif.rdata = {26'h0000000, evt};
      default: rif.rdata = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------
  // Lock detectors
  // ---------------------------------------------------------------
  mflc_lock_detect u_lock (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .speed_pct(speed_pct),
    .backemf_pct(backemf_pct),
    .current_ma(current_ma),
    .overspeed_lock_on(setup_b_r[MFLC_B_OVS_ON]),
    .low_backemf_lock_on(setup_b_r[MFLC_B_BEMF_ON]),
    .absent_motor_lock_on(setup_b_r[MFLC_B_NOMTR_ON]),
    .overspeed_lock_level(setup_b_r[MFLC_B_OVS_LVL +: 3]),
    .backemf_lock_level(setup_b_r[MFLC_B_BEMF_LVL +: 3]),
    .absent_motor_current_level(setup_b_r[MFLC_B_NOMTR_LVL +: 3]),
    .ovs_fault(ovs_f),
    .bemf_fault(bemf_f),
    .nomtr_fault(nomtr_f)
  );

  // ---------------------------------------------------------------
  // Fault outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      overspeed_lock_fault <= 1'b0;
      low_backemf_lock_fault <= 1'b0;
      absent_motor_lock_fault <= 1'b0;
    end else begin
      overspeed_lock_fault <= ovs_f;
      low_backemf_lock_fault <= bemf_f;
      absent_motor_lock_fault <= nomtr_f;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      init_position_timeout_fault <= 1'b0;
      init_position_freq_fault <= 1'b0;
      loop_sat_report <= 2'h0;
    end else begin
      init_position_timeout_fault <= ipd_timeout_evt && setup_a_r[MFLC_A_IPD_TIMEOUT];
      init_position_freq_fault <= ipd_freq_evt && setup_a_r[MFLC_A_IPD_FREQ];
      loop_sat_report <= {spd_loop_sat, cur_loop_sat} & {2{setup_a_r[MFLC_A_SAT]}};
    end
  end

  // ---------------------------------------------------------------
  // Current-limit lock response
  // ---------------------------------------------------------------
  assign ilim_code = setup_b_r[MFLC_B_ILIM_ACT +: 4];
  assign ilim = mflc_ilim_decode(ilim_code, hw_ilimit_evt);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ilim_fault_latch <= 1'b0;
      ilim_fault_retry <= 1'b0;
      ilim_report_only <= 1'b0;
      ilim_gate_action <= 2'h0;
    end else begin
      ilim_fault_latch <= ilim.latch;
      ilim_fault_retry <= ilim.retry;
      ilim_report_only <= ilim.report;
      ilim_gate_action <= ilim.action;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  assign evt = {ilim.latch | ilim.retry | ilim.report,
                init_position_freq_fault, init_position_timeout_fault,
                absent_motor_lock_fault, low_backemf_lock_fault, overspeed_lock_fault};

  // Only bits the master actually saw are cleared, so a late event survives
  assign rd_clr = (rif.rd_en && rif.idx == MFLC_IDX_STATUS) ? rif.rd_data[5:0] : 6'h00;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_r <= MFLC_EVT_RST;
    end else begin
      status_r <= (status_r & ~rd_clr) | evt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_ipd_timeout;
    ipd_timeout_evt |=> init_position_timeout_fault == $past(setup_a_r[MFLC_A_IPD_TIMEOUT]);
  endproperty
  a_ipd_timeout: assert property (p_ipd_timeout) else $error("timeout fault gating wrong");

  property p_ipd_freq;
    !setup_a_r[MFLC_A_IPD_FREQ] |=> !init_position_freq_fault;
  endproperty
  a_ipd_freq: assert property (p_ipd_freq) else $error("freq fault while disabled");

  property p_sat;
    setup_a_r[MFLC_A_SAT] && cur_loop_sat && spd_loop_sat |=> loop_sat_report == 2'h3;
  endproperty
  a_sat: assert property (p_sat) else $error("saturation report missing");

  property p_b_reset;
    @(posedge ref_clk) disable iff (1'b0) !rst_n |=> setup_b_r == MFLC_SETUP_B_RST;
  endproperty
  a_b_reset: assert property (p_b_reset) else $error("setup B reset not zero");

  sequence s_full_write_b;
    rif.wr_en && rif.idx == MFLC_IDX_SETUP_B && rif.sel == 4'hf;
  endsequence

  property p_b_readback;
    s_full_write_b |=> setup_b_r == $past(rif.wdata);
  endproperty
  a_b_readback: assert property (p_b_readback) else $error("setup B write lost");

  property p_ilim_latch;
    hw_ilimit_evt && ilim_code == 4'h2 |=> ilim_fault_latch && ilim_gate_action == 2'h2;
  endproperty
  a_ilim_latch: assert property (p_ilim_latch) else $error("latch response wrong");

  property p_ilim_off;
    ilim_code > MFLC_ILIM_REPORT |=> !ilim_fault_latch && !ilim_fault_retry && !ilim_report_only;
  endproperty
  a_ilim_off: assert property (p_ilim_off) else $error("disabled code responded");

  property p_irq;
    |(status_r & mask_r) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule : mflc_top

// ### mflc_top_tb.sv
// Self-checking testbench for the fault and motor-lock setup register bank
`timescale 1ns/1ns
module mflc_top_tb;
  import mflc_pkg::*;
  logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [11:0] wb_adr_i, current_ma;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, seed, m_b;
  logic [7:0] speed_pct, backemf_pct;
  logic ipd_timeout_evt, ipd_freq_evt, cur_loop_sat, spd_loop_sat, hw_ilimit_evt;
  logic overspeed_lock_fault, low_backemf_lock_fault, absent_motor_lock_fault;
  logic init_position_timeout_fault, init_position_freq_fault;
  logic ilim_fault_latch, ilim_fault_retry, ilim_report_only;
  logic [1:0] loop_sat_report, ilim_gate_action;
  int err_total, n_checks;
  int ma_tab[8] = '{50, 75, 100, 125, 250, 500, 750, 1000};

  mflc_top DUT (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .speed_pct, .backemf_pct, .current_ma,
    .ipd_timeout_evt, .ipd_freq_evt, .cur_loop_sat, .spd_loop_sat, .hw_ilimit_evt,
    .overspeed_lock_fault, .low_backemf_lock_fault, .absent_motor_lock_fault,
    .init_position_timeout_fault, .init_position_freq_fault, .loop_sat_report,
    .ilim_fault_latch, .ilim_fault_retry, .ilim_report_only, .ilim_gate_action, .irq);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0, 4'h0);
    chk(nm, rd, e);
  endtask : rdchk

  // Measurements pass a two-flop synchroniser, so allow the full latency
  task automatic meas(input int s, input int b, input int c);
    @(posedge ref_clk);
    speed_pct <= 8'(s);
    backemf_pct <= 8'(b);
    current_ma <= 12'(c);
    repeat (6) @(posedge ref_clk);
  endtask : meas

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // Clock, watchdog and sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    test_done();
  end

  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {ipd_timeout_evt, ipd_freq_evt, cur_loop_sat, spd_loop_sat, hw_ilimit_evt} = '0;
    speed_pct = 8'h00;
    backemf_pct = 8'hff;
    current_ma = 12'hfff;
    seed = 32'h0000004b;
    m_b = 32'h0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(12'h248, 32'h0, "setup_b");
    rdchk(12'h244, 32'h0, "setup_a");
    // Masked event sets status only; unmasking raises irq, read clears it
    wb(1'b1, 12'h244, 32'h4, 4'hf);
    @(posedge ref_clk) ipd_timeout_evt <= 1'b1;
    @(posedge ref_clk) ipd_timeout_evt <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("irq", irq, 32'h0);
    wb(1'b1, 12'h250, 32'h8, 4'hf);
    repeat (2) @(posedge ref_clk);
    chk("irq", irq, 32'h1);
    rdchk(12'h250, 32'h8, "mask");
    rdchk(12'h24c, 32'h8, "status");
    repeat (2) @(posedge ref_clk);
    chk("irq", irq, 32'h0);
    rdchk(12'h24c, 32'h0, "status");
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, 12'h244, 32'(i), 4'hf);
      {ipd_timeout_evt, ipd_freq_evt, cur_loop_sat, spd_loop_sat} <= 4'hf;
      repeat (3) @(posedge ref_clk);
      chk("ipd_timeout", init_position_timeout_fault, 32'(i[2]));
      chk("ipd_freq", init_position_freq_fault, 32'(i[1]));
      chk("loop_sat", loop_sat_report, i[0] ? 32'h3 : 32'h0);
      {ipd_timeout_evt, ipd_freq_evt, cur_loop_sat, spd_loop_sat} <= 4'h0;
    end
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wb(1'b1, 12'h248, seed, seed[3:0]);
      for (int k = 0; k < 4; k++) if (seed[k]) m_b[8*k +: 8] = seed[8*k +: 8];
      rdchk(12'h248, m_b, "setup_b");
      wb(1'b1, 12'h244, ~seed, 4'hf);
      rdchk(12'h244, ~seed & 32'h7, "setup_a");
      wb(1'b1, 12'h000, seed, 4'hf);
      rdchk(12'h000, 32'h0, "unmapped");
    end
    for (int c = 0; c < 8; c++) begin
      m_b = 32'h70000000 | (c << 25) | (c << 22) | (c << 19);
      wb(1'b1, 12'h248, m_b, 4'hf);
      meas(130 + 10 * c, 9 + 10 * c, ma_tab[c] - 1);
      chk("locks", {overspeed_lock_fault, low_backemf_lock_fault, absent_motor_lock_fault},
          32'h7);
      meas(129 + 10 * c, 10 + 10 * c, ma_tab[c]);
      chk("locks", {overspeed_lock_fault, low_backemf_lock_fault, absent_motor_lock_fault},
          32'h0);
    end
    wb(1'b1, 12'h248, 32'h0, 4'hf);
    meas(255, 0, 0);
    chk("locks", {overspeed_lock_fault, low_backemf_lock_fault, absent_motor_lock_fault},
        32'h0);
    hw_ilimit_evt <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      wb(1'b1, 12'h248, 32'(c) << 15, 4'hf);
      repeat (3) @(posedge ref_clk);
      chk("ilim", {ilim_fault_latch, ilim_fault_retry, ilim_report_only, ilim_gate_action},
          {c < 4, c >= 4 && c < 8, c == 8, c < 8 ? 2'(c) : 2'h0});
      rdchk(12'h254, (c <= 8) ? 32'h20 : 32'h0, "state");
    end
    test_done();
  end
endmodule : mflc_top_tb

// ### mflc_wb_slave.sv
// Classic Wishbone slave front end for the register bank
`timescale 1ns/1ns
module mflc_wb_slave
  import mflc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Register side
  mflc_reg_if.slave rif
);
  import mflc_pkg::*;

  mflc_bus_state_type state_r;
  logic req;

  assign req = wb_cyc_i && wb_stb_i;

  // ---------------------------------------------------------------
  // Handshake: data captured on request, ack one cycle later
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= MFLC_BUS_IDLE;
    end else begin
      case (state_r)
        MFLC_BUS_IDLE: if (req) state_r <= MFLC_BUS_ACK;
        MFLC_BUS_ACK: state_r <= MFLC_BUS_IDLE;
        default: state_r <= MFLC_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (req && state_r == MFLC_BUS_IDLE) begin
      wb_dat_o <= wb_we_i ? 32'h00000000 : rif.rdata;
    end
  end

  assign wb_ack_o = (state_r == MFLC_BUS_ACK);

  // Effects land on the ack edge, the one edge the master commits at
  assign rif.wr_en = req && wb_ack_o && wb_we_i;
  assign rif.rd_en = req && wb_ack_o && !wb_we_i;
  assign rif.idx = wb_adr_i[9:2];
  assign rif.wdata = wb_dat_i;
  assign rif.sel = wb_sel_i;
  assign rif.rd_data = wb_dat_o;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_new_req;
    req && !wb_ack_o;
  endsequence

  sequence s_one_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_ack_once;
    @(posedge ref_clk) disable iff (!rst_n) s_new_req |=> s_one_ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");

endmodule : mflc_wb_slave
